// ===== hpd_map.svh
// register indices, field positions, reset values and bus codes for the hub power descriptor bank
`ifndef HPD_MAP_SVH
`define HPD_MAP_SVH

// --------------------------------------------------------------------------
// register indices (byte address is four times the index)
// --------------------------------------------------------------------------
`define HPD_IDX_BUS_POWERED_MAX_POWER 8'h0d
`define HPD_IDX_SELFPOWERED_CTRL_CUR 8'h0e
`define HPD_IDX_BUSPOWERED_CTRL_CUR 8'h0f
`define HPD_IDX_PORT_POWER_ON_TIME 8'h10
`define HPD_IDX_LANGUAGE_ID_HIGH 8'h11
`define HPD_IDX_LANGUAGE_ID_LOW 8'h12
`define HPD_IDX_STATUS 8'hf0

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define HPD_RST_BUS_POWERED_MAX_POWER 8'hfa
`define HPD_RST_SELFPOWERED_CTRL_CUR 8'h02
`define HPD_RST_BUSPOWERED_CTRL_CUR 8'h64
`define HPD_RST_PORT_POWER_ON_TIME 8'h00
`define HPD_RST_LANGUAGE_ID_HIGH 8'h04
`define HPD_RST_LANGUAGE_ID_LOW 8'h09

// --------------------------------------------------------------------------
// status fields and limits
// --------------------------------------------------------------------------
`define HPD_STAT_SP_OVER_BIT 0
`define HPD_STAT_BAD_ACCESS_BIT 1
`define HPD_SP_CURRENT_LIMIT 8'h64

// --------------------------------------------------------------------------
// bus answer codes and address layout
// --------------------------------------------------------------------------
`define HPD_RESP_OKAY 2'h0
`define HPD_RESP_SLVERR 2'h2
`define HPD_IDX_LSB 2
`define HPD_IDX_TOP 10

`endif

// ===== hpd_pkg.sv
// types shared by the hub power descriptor bank
package hpd_pkg;

    // ----------------------------------------------------------------------
    // write path states of the bus front end
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        HPD_WR_COLLECT = 2'b00,
        HPD_WR_ISSUE = 2'b01,
        HPD_WR_RESP = 2'b10
    } hpd_wr_e;

    // ----------------------------------------------------------------------
    // front end state
    // ----------------------------------------------------------------------
    typedef struct packed {
        hpd_wr_e wst;
        logic aw_got;
        logic w_got;
        logic [7:0] widx;
        logic waligned;
        logic [7:0] wdata;
        logic wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } hpd_axi_s;

    // ----------------------------------------------------------------------
    // register bank state
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] bus_power_limit;
        logic [7:0] sp_controller_current;
        logic [7:0] bp_controller_current;
        logic [7:0] port_power_on_time;
        logic [7:0] language_upper_byte;
        logic [7:0] language_lower_byte;
        logic bad_access;
        logic [5:0] touched;
    } hpd_bank_s;

endpackage : hpd_pkg

// ===== hpd_reg_if.sv
// single-cycle register request path between the bus front end and the bank
`timescale 1ns/1ps
interface hpd_reg_if;
    logic req;
    logic we;
    logic [7:0] idx;
    logic addr_ok;
    logic [7:0] wdata;
    logic wstrb;
    logic [7:0] rdata;
    logic hit;

    modport initiator (output req, output we, output idx, output addr_ok, output wdata, output wstrb,
                       input rdata, input hit);
    modport target (input req, input we, input idx, input addr_ok, input wdata, input wstrb,
                    output rdata, output hit);
endinterface : hpd_reg_if

// ===== hpd_axil_slave.sv
// axi4-lite slave front end turning bus transfers into single-cycle register requests
`timescale 1ns/1ps
`include "hpd_map.svh"
module hpd_axil_slave #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address and data
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // bank side
    hpd_reg_if.initiator rif
);

    // ----------------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------------
    if (ADDR_W < `HPD_IDX_TOP) begin : g_bad_addr_w
        $error("ADDR_W too small for the register index");
    end

    // ----------------------------------------------------------------------
    // address decode: index plus alignment and range check
    // ----------------------------------------------------------------------
    function automatic logic [8:0] addr_decode(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a[1:0] == 2'h0) && ((a >> `HPD_IDX_TOP) == '0);
        return {ok, a[`HPD_IDX_TOP-1:`HPD_IDX_LSB]};
    endfunction : addr_decode

    hpd_pkg::hpd_axi_s q_ff;
    hpd_pkg::hpd_axi_s nxt_q;
    logic ar_take;
    logic [8:0] ar_dec;
    logic [8:0] aw_dec;

    assign ar_dec = addr_decode(araddr);
    assign aw_dec = addr_decode(awaddr);
    // a pending write owns the request path; arready is low then
    assign ar_take = arvalid && q_ff.arready;

    assign rif.req = (q_ff.wst == hpd_pkg::HPD_WR_ISSUE) || ar_take;
    assign rif.we = (q_ff.wst == hpd_pkg::HPD_WR_ISSUE);
    assign rif.idx = rif.we ? q_ff.widx : ar_dec[7:0];
    assign rif.addr_ok = rif.we ? q_ff.waligned : ar_dec[8];
    assign rif.wdata = q_ff.wdata;
    assign rif.wstrb = q_ff.wstrb;

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        case (q_ff.wst)
            hpd_pkg::HPD_WR_COLLECT: begin
                if (awvalid && q_ff.awready) begin
                    nxt_q.aw_got = 1'b1;
                    nxt_q.widx = aw_dec[7:0];
                    nxt_q.waligned = aw_dec[8];
                end
                if (wvalid && q_ff.wready) begin
                    nxt_q.w_got = 1'b1;
                    nxt_q.wdata = wdata[7:0];
                    nxt_q.wstrb = wstrb[0];
                end
                if (nxt_q.aw_got && nxt_q.w_got) begin
                    nxt_q.wst = hpd_pkg::HPD_WR_ISSUE;
                end
            end
            hpd_pkg::HPD_WR_ISSUE: begin
                nxt_q.bvalid = 1'b1;
                nxt_q.bresp = rif.hit ? `HPD_RESP_OKAY : `HPD_RESP_SLVERR;
                nxt_q.aw_got = 1'b0;
                nxt_q.w_got = 1'b0;
                nxt_q.wst = hpd_pkg::HPD_WR_RESP;
            end
            hpd_pkg::HPD_WR_RESP: begin
                if (bready) begin
                    nxt_q.bvalid = 1'b0;
                    nxt_q.wst = hpd_pkg::HPD_WR_COLLECT;
                end
            end
            default: begin
                nxt_q.wst = hpd_pkg::HPD_WR_COLLECT;
            end
        endcase
        if (q_ff.rvalid && rready) begin
            nxt_q.rvalid = 1'b0;
        end
        if (ar_take) begin
            nxt_q.rvalid = 1'b1;
            nxt_q.rdata = rif.hit ? rif.rdata : 8'h00;
            nxt_q.rresp = rif.hit ? `HPD_RESP_OKAY : `HPD_RESP_SLVERR;
        end
        nxt_q.awready = (nxt_q.wst == hpd_pkg::HPD_WR_COLLECT) && !nxt_q.aw_got;
        nxt_q.wready = (nxt_q.wst == hpd_pkg::HPD_WR_COLLECT) && !nxt_q.w_got;
        nxt_q.arready = !nxt_q.rvalid && (nxt_q.wst != hpd_pkg::HPD_WR_ISSUE);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign awready = q_ff.awready;
    assign wready = q_ff.wready;
    assign bvalid = q_ff.bvalid;
    assign bresp = q_ff.bresp;
    assign arready = q_ff.arready;
    assign rvalid = q_ff.rvalid;
    assign rresp = q_ff.rresp;
    assign rdata = {24'h000000, q_ff.rdata};

endmodule : hpd_axil_slave

// ===== hpd_power_desc_regs.sv
// hub power descriptor configuration bank with axi4-lite access
//
// Behaviour
// R1 - bus-powered max power: 8 bits, 2 mA units, resets to 0xfa (500 mA).
// R2 - software includes silicon, board and zero-reporting embedded peripheral in that value.
// R3 - self-powered controller current: 8 bits, 1 mA units, resets to 0x02.
// R4 - software excludes attached peripheral from self-powered controller current.
// R5 - bus-powered controller current: 8 bits, 1 mA units, resets to 0x64.
// R6 - software includes silicon and board, excludes attached peripheral, in bus-powered current.
// R7 - software keeps self-powered controller current at or below 100 mA.
// R8 - power-on time: 8 bits, 2 ms units, port power start to good, resets 0x00.
// R9 - power-on time drives only the descriptor power-on-to-good field.
// R10 - software sets power-on time zero without switch, maximum with serial-controlled switch.
// R11 - language id high supplies upper byte of 16-bit id, resets to 0x04.
// R12 - language id low supplies lower byte, resets to 0x09, giving 0x0409.
// R13 - each register keeps its default until written, then presents written value unchanged.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "hpd_map.svh"
module hpd_power_desc_regs #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // descriptor values
    output logic [7:0] BUS_POWER_LIMIT_FIELD,
    output logic [7:0] SP_CONTROLLER_CURRENT_FIELD,
    output logic [7:0] BP_CONTROLLER_CURRENT_FIELD,
    output logic [7:0] PWR_ON_TO_PWR_GOOD,
    output logic [15:0] LANGUAGE_ID
);

    // ----------------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------------
    if (ADDR_W < `HPD_IDX_TOP) begin : g_bad_addr_w
        $error("ADDR_W too small for the register index");
    end

    // ----------------------------------------------------------------------
    // bus front end
    // ----------------------------------------------------------------------
    hpd_reg_if rif ();

    hpd_axil_slave #(
        .ADDR_W(ADDR_W)
    ) u_axil (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .rif(rif.initiator)
    );

    // ----------------------------------------------------------------------
    // decode and read mux
    // ----------------------------------------------------------------------
    hpd_pkg::hpd_bank_s q_ff;
    hpd_pkg::hpd_bank_s nxt_q;
    logic [6:0] sel;
    logic wr_go;
    logic sp_over;

    // one-hot select: six config bytes then status; alignment failure selects nothing
    function automatic logic [6:0] reg_select(input logic [7:0] idx, input logic ok);
        logic [6:0] s;
        s = 7'h00;
        if (ok) begin
            case (idx)
                `HPD_IDX_BUS_POWERED_MAX_POWER: s = 7'h01;
                `HPD_IDX_SELFPOWERED_CTRL_CUR: s = 7'h02;
                `HPD_IDX_BUSPOWERED_CTRL_CUR: s = 7'h04;
                `HPD_IDX_PORT_POWER_ON_TIME: s = 7'h08;
                `HPD_IDX_LANGUAGE_ID_HIGH: s = 7'h10;
                `HPD_IDX_LANGUAGE_ID_LOW: s = 7'h20;
                `HPD_IDX_STATUS: s = 7'h40;
                default: s = 7'h00;
            endcase
        end
        return s;
    endfunction : reg_select

    assign sel = reg_select(rif.idx, rif.addr_ok);
    assign rif.hit = |sel;
    // a write with byte lane 0 off is accepted but leaves the bytes alone
    assign wr_go = rif.req && rif.we && rif.wstrb;
    // software is not meant to exceed the limit; the bank only reports it
    assign sp_over = q_ff.sp_controller_current > `HPD_SP_CURRENT_LIMIT; // R7

    always_comb begin
        rif.rdata = 8'h00;
        case (sel)
            7'h01: rif.rdata = q_ff.bus_power_limit;
            7'h02: rif.rdata = q_ff.sp_controller_current;
            7'h04: rif.rdata = q_ff.bp_controller_current;
            7'h08: rif.rdata = q_ff.port_power_on_time;
            7'h10: rif.rdata = q_ff.language_upper_byte;
            7'h20: rif.rdata = q_ff.language_lower_byte;
            7'h40: begin
                rif.rdata[`HPD_STAT_SP_OVER_BIT] = sp_over;
                rif.rdata[`HPD_STAT_BAD_ACCESS_BIT] = q_ff.bad_access;
            end
            default: rif.rdata = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------------
    // register bank
    // ----------------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        if (wr_go && sel[0]) begin
            nxt_q.bus_power_limit = rif.wdata; // R1
        end
        if (wr_go && sel[1]) begin
            nxt_q.sp_controller_current = rif.wdata; // R3
        end
        if (wr_go && sel[2]) begin
            nxt_q.bp_controller_current = rif.wdata; // R5
        end
        if (wr_go && sel[3]) begin
            nxt_q.port_power_on_time = rif.wdata; // R8
        end
        if (wr_go && sel[4]) begin
            nxt_q.language_upper_byte = rif.wdata; // R11
        end
        if (wr_go && sel[5]) begin
            nxt_q.language_lower_byte = rif.wdata; // R12
        end
        if (wr_go) begin
            nxt_q.touched = q_ff.touched | sel[5:0]; // R13
        end
        // write-one clears; a new bad access in the same cycle wins
        if (wr_go && sel[6] && rif.wdata[`HPD_STAT_BAD_ACCESS_BIT]) begin
            nxt_q.bad_access = 1'b0;
        end
        if (rif.req && !rif.hit) begin
            nxt_q.bad_access = 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            q_ff.bus_power_limit <= `HPD_RST_BUS_POWERED_MAX_POWER; // R1
            q_ff.sp_controller_current <= `HPD_RST_SELFPOWERED_CTRL_CUR; // R3
            q_ff.bp_controller_current <= `HPD_RST_BUSPOWERED_CTRL_CUR; // R5
            q_ff.port_power_on_time <= `HPD_RST_PORT_POWER_ON_TIME; // R8
            q_ff.language_upper_byte <= `HPD_RST_LANGUAGE_ID_HIGH; // R11
            q_ff.language_lower_byte <= `HPD_RST_LANGUAGE_ID_LOW; // R12
            q_ff.bad_access <= 1'b0;
            q_ff.touched <= 6'h00;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ----------------------------------------------------------------------
    // descriptor outputs, straight from the bank flops
    // ----------------------------------------------------------------------
    assign BUS_POWER_LIMIT_FIELD = q_ff.bus_power_limit; // R13
    assign SP_CONTROLLER_CURRENT_FIELD = q_ff.sp_controller_current;
    assign BP_CONTROLLER_CURRENT_FIELD = q_ff.bp_controller_current;
    // power-on time feeds only this descriptor field, no port timing here
    assign PWR_ON_TO_PWR_GOOD = q_ff.port_power_on_time; // R9
    assign LANGUAGE_ID = {q_ff.language_upper_byte, q_ff.language_lower_byte}; // R11 R12

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);

    sequence write_to(logic [6:0] s);
        wr_go && ((sel & s) != 7'h00);
    endsequence

    sequence aw_w_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence

    bus_power_default_a: assert property ( // R1
        !q_ff.touched[0] |-> BUS_POWER_LIMIT_FIELD == `HPD_RST_BUS_POWERED_MAX_POWER)
        else $error("bus power limit left its default without a write");

    sp_current_default_a: assert property ( // R3
        !q_ff.touched[1] |-> SP_CONTROLLER_CURRENT_FIELD == `HPD_RST_SELFPOWERED_CTRL_CUR)
        else $error("self-powered current left its default without a write");

    bp_current_default_a: assert property ( // R5
        !q_ff.touched[2] |-> BP_CONTROLLER_CURRENT_FIELD == `HPD_RST_BUSPOWERED_CTRL_CUR)
        else $error("bus-powered current left its default without a write");

    power_on_write_a: assert property ( // R8
        write_to(7'h08) |=> PWR_ON_TO_PWR_GOOD == $past(rif.wdata))
        else $error("power-on time did not take the written value");

    power_on_isolated_a: assert property ( // R9
        write_to(7'h08) |=> $stable(BUS_POWER_LIMIT_FIELD) && $stable(SP_CONTROLLER_CURRENT_FIELD)
            && $stable(BP_CONTROLLER_CURRENT_FIELD) && $stable(LANGUAGE_ID))
        else $error("power-on time write disturbed another field");

    lang_high_default_a: assert property ( // R11
        !q_ff.touched[4] |-> LANGUAGE_ID[15:8] == `HPD_RST_LANGUAGE_ID_HIGH)
        else $error("language id upper byte left its default without a write");

    lang_low_write_a: assert property ( // R12
        write_to(7'h20) |=> LANGUAGE_ID[7:0] == $past(rif.wdata) && $stable(LANGUAGE_ID[15:8]))
        else $error("language id lower byte did not take the written value");

    lang_low_default_a: assert property ( // R12
        !q_ff.touched[5] |-> LANGUAGE_ID[7:0] == `HPD_RST_LANGUAGE_ID_LOW)
        else $error("language id lower byte left its default without a write");

    fields_hold_a: assert property ( // R13
        !wr_go |=> $stable(BUS_POWER_LIMIT_FIELD) && $stable(SP_CONTROLLER_CURRENT_FIELD)
            && $stable(BP_CONTROLLER_CURRENT_FIELD) && $stable(PWR_ON_TO_PWR_GOOD) && $stable(LANGUAGE_ID))
        else $error("a field changed without a write");

    bus_write_path_a: assert property ( // R13
        aw_w_taken ##0 (S_AXI_AWADDR == ADDR_W'(4 * `HPD_IDX_BUS_POWERED_MAX_POWER)) && S_AXI_WSTRB[0]
        |=> ##[1:2] BUS_POWER_LIMIT_FIELD == $past(S_AXI_WDATA[7:0], 2) && S_AXI_BVALID)
        else $error("bus write did not reach the bus power limit field");

    write_answer_a: assert property ( // R13
        aw_w_taken |-> ##2 S_AXI_BVALID)
        else $error("write response not raised two cycles after address and data");

endmodule : hpd_power_desc_regs

// ===== hpd_host_model.sv
// behavioural upstream host that snapshots the descriptor fields it reports
`timescale 1ns/1ps
module hpd_host_model (
    // clock and request
    input wire logic clk,
    input wire logic fetch,
    // descriptor fields from the bank
    input wire logic [7:0] pwr_good_in,
    input wire logic [15:0] lang_in,
    // snapshot as the host sees it
    output logic [7:0] snap_pwr,
    output logic [15:0] snap_lang
);
    // sampled on the request edge only, so a later write cannot leak into a finished fetch
    // power values are taken as board totals and never recomputed here
    always_ff @(posedge clk) begin
        if (fetch) begin
            snap_pwr <= pwr_good_in;
            snap_lang <= lang_in;
        end
    end
endmodule : hpd_host_model

// ===== tb.sv
// self-checking bench for the hub power descriptor bank
`timescale 1ns/1ps
`include "hpd_map.svh"
module tb;
    logic clock = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, fetch = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] f_limit, f_sp, f_bp, f_pwr, snap_pwr;
    logic [15:0] f_lang, snap_lang;
    logic [7:0] exp_q [6];
    localparam logic [7:0] idx_tab [6] = '{`HPD_IDX_BUS_POWERED_MAX_POWER, `HPD_IDX_SELFPOWERED_CTRL_CUR,
        `HPD_IDX_BUSPOWERED_CTRL_CUR, `HPD_IDX_PORT_POWER_ON_TIME, `HPD_IDX_LANGUAGE_ID_HIGH,
        `HPD_IDX_LANGUAGE_ID_LOW};
    int fail_count = 0, samples_checked = 0, cycles = 0;

    hpd_power_desc_regs dut_u (.CLOCK(clock), .ARST_N(arst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .BUS_POWER_LIMIT_FIELD(f_limit), .SP_CONTROLLER_CURRENT_FIELD(f_sp),
        .BP_CONTROLLER_CURRENT_FIELD(f_bp), .PWR_ON_TO_PWR_GOOD(f_pwr), .LANGUAGE_ID(f_lang));

    hpd_host_model host_u (.clk(clock), .fetch(fetch), .pwr_good_in(f_pwr), .lang_in(f_lang),
        .snap_pwr(snap_pwr), .snap_lang(snap_lang));

    always #20 clock = ~clock;

    // a hang is cut short well above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    // ----------------------------------------------------------------------
    // comparison and bus tasks
    // ----------------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic check_outs;
        check({24'h000000, f_limit}, {24'h000000, exp_q[0]});
        check({24'h000000, f_sp}, {24'h000000, exp_q[1]});
        check({24'h000000, f_bp}, {24'h000000, exp_q[2]});
        check({24'h000000, f_pwr}, {24'h000000, exp_q[3]});
        check({16'h0000, f_lang}, {16'h0000, exp_q[4], exp_q[5]});
    endtask : check_outs

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic s, output logic [1:0] resp);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        // every request starts on an edge, so back-to-back calls never assign one signal twice in a step
        @(posedge clock);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h000000, d};
        wstrb <= {3'b000, s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge clock);
            if (aw_p && awready === 1'b1) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready === 1'b1) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clock);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic put(input int i, input logic [7:0] d);
        logic [1:0] r;
        logic [31:0] q;
        wr(idx_tab[i], d, 1'b1, r);
        exp_q[i] = d;
        #1;
        check({30'h00000000, r}, {30'h00000000, `HPD_RESP_OKAY});
        check_outs;
        rd(idx_tab[i], q, r);
        check(q, {24'h000000, d});
    endtask : put

    // ----------------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------------
    initial begin
        logic [1:0] r;
        logic [31:0] q;
        logic [7:0] d;
        int j;
        exp_q = '{`HPD_RST_BUS_POWERED_MAX_POWER, `HPD_RST_SELFPOWERED_CTRL_CUR, `HPD_RST_BUSPOWERED_CTRL_CUR,
            `HPD_RST_PORT_POWER_ON_TIME, `HPD_RST_LANGUAGE_ID_HIGH, `HPD_RST_LANGUAGE_ID_LOW};
        void'($urandom(65008));
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        #1;
        check_outs;
        for (j = 0; j < 6; j++) begin
            rd(idx_tab[j], q, r);
            check(q, {24'h000000, exp_q[j]});
        end
        put(3, 8'hff);
        put(3, 8'h00);
        put(1, `HPD_SP_CURRENT_LIMIT);
        for (j = 0; j < 40; j++) begin
            d = 8'($urandom);
            // software keeps the self-powered figure at or below 100 mA
            if (j % 6 == 1)
                d = d % 8'h65;
            put(j % 6, d);
        end
        wr(8'h13, 8'h5a, 1'b1, r);
        #1;
        check({30'h00000000, r}, {30'h00000000, `HPD_RESP_SLVERR});
        check_outs;
        rd(8'h13, q, r);
        check({30'h0, r}, {30'h0, `HPD_RESP_SLVERR});
        check(q, 32'h00000000);
        wr(idx_tab[2], 8'h11, 1'b0, r);
        #1;
        check_outs;
        check({30'h0, r}, {30'h0, `HPD_RESP_OKAY});
        // status: sticky bad-access bit from the unmapped accesses, live over-limit bit
        rd(`HPD_IDX_STATUS, q, r);
        check(q, {30'h0, 1'b1, exp_q[1] > `HPD_SP_CURRENT_LIMIT});
        wr(`HPD_IDX_STATUS, 8'h02, 1'b1, r);
        rd(`HPD_IDX_STATUS, q, r);
        check(q, {31'h0, exp_q[1] > `HPD_SP_CURRENT_LIMIT});
        fetch <= 1'b1;
        @(posedge clock);
        fetch <= 1'b0;
        @(posedge clock);
        #1;
        check({24'h000000, snap_pwr}, {24'h000000, exp_q[3]});
        check({16'h0000, snap_lang}, {16'h0000, exp_q[4], exp_q[5]});
        summarize();
    end
endmodule : tb
